/* rtl/shfa_map.vh */
// constants for the five-port hub arbiter: ids, port indices, phases, registers
// assumes inclusion by bare name from the hub arbiter design file
// Functional notes
// - fair mode replaces plain priority arbitration among host ports
// - only host ports rotate; controller port always outranks hosts
// - front selector input chooses fair enabled or disabled
// - hub always holds id 7; no attached device may use it
// - in fair mode hub wins arbitration and captures requesting host ids
// - grant goes to the highest captured id
// - granted id leaves the captured group before next comparison
// - after a grant ends, serve next captured id without new capture
// - when group is empty, capture afresh at the next arbitration
// - fair mode off: highest asserted id wins conventionally
// - fair mode off: host ids are not tied to physical ports
// - fair mode on: each host port has a fixed id in both address modes
// - jumper fitted: hosts use ids 0-3, controller ids 4-6
// - jumper removed: hosts use ids 12-15, controller ids 0-6
// - a port losing termination power is disabled alone
// - drive power indicator, and busy indicator while bus is busy
`ifndef SHFA_MAP_VH
`define SHFA_MAP_VH

// scsi id numbers
`define SHFA_HUB_ID        4'h7
`define SHFA_NARROW_HOST0  4'h0
`define SHFA_WIDE_HOST0    4'hc
`define SHFA_NARROW_CTL_LO 4'h4
`define SHFA_WIDE_CTL_LO   4'h0
`define SHFA_CTL_HI        4'h6

// port layout: ports 0..3 are hosts, port 4 is the controller port
`define SHFA_CTL_PORT      3'h4

// fair arbiter states
`define SHFA_ST_IDLE       2'h0
`define SHFA_ST_GRANT      2'h1
`define SHFA_ST_WAIT       2'h2

// register indices
`define SHFA_REG_CTRL      4'h0
`define SHFA_REG_STAT      4'h1
`define SHFA_REG_IRQ       4'h2
`define SHFA_REG_MASK      4'h3
`define SHFA_REG_GRANT     4'h4

// interrupt event bits
`define SHFA_EV_TPWR_LOST  0
`define SHFA_EV_GRANT      1
`define SHFA_EV_CAPTURE    2
`define SHFA_EV_BADID      3

// reset values
`define SHFA_CTRL_RST      8'h0_0
`define SHFA_MASK_RST      8'h0_0

`endif

/* rtl/shfa_hub_arbiter.v */
// five-port hub arbitration core: port enable, fair capture and grant, bus or
// assumes each segment's scsi bus signals already sampled synchronous to clock_in;
// selector and jumper inputs are static straps sampled every cycle
//
// Chosen here: the address map and the strobed register port.
`include "shfa_map.vh"

module shfa_hub_arbiter #(
  parameter NPORT = 5,
  parameter IDW   = 16
) (
  // clock and reset
  input  wire             clock_in,
  input  wire             rstn_in,
  // panel straps
  input  wire             fair_sel_in,
  input  wire             addr_mode_jumper_in,
  // per-port segment state
  input  wire [NPORT-1:0] tpwr_in,
  input  wire [NPORT-1:0] seg_bsy_in,
  input  wire [NPORT-1:0] seg_sel_in,
  input  wire [IDW-1:0]   seg_id0_in,
  input  wire [IDW-1:0]   seg_id1_in,
  input  wire [IDW-1:0]   seg_id2_in,
  input  wire [IDW-1:0]   seg_id3_in,
  input  wire [IDW-1:0]   seg_id4_in,
  // register port
  input  wire [3:0]       reg_addr_in,
  input  wire [7:0]       reg_wdata_in,
  input  wire             reg_wr_in,
  input  wire             reg_rd_in,
  output reg  [7:0]       reg_rdata_out,
  // segment drive
  output reg  [NPORT-1:0] port_en_out,
  output reg              bus_bsy_out,
  output reg              bus_sel_out,
  output reg  [IDW-1:0]   bus_id_out,
  output reg  [IDW-1:0]   grant_id_out,
  output reg              grant_valid_out,
  // indicators and interrupt
  output reg              power_led_out,
  output reg              busy_led_out,
  output reg              irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // port id map
  wire [3:0] host_base = addr_mode_jumper_in ? `SHFA_NARROW_HOST0 : `SHFA_WIDE_HOST0;
  wire [3:0] ctl_lo    = addr_mode_jumper_in ? `SHFA_NARROW_CTL_LO : `SHFA_WIDE_CTL_LO;
  wire [IDW-1:0] seg_id [0:NPORT-1];
  assign seg_id[0] = seg_id0_in;
  assign seg_id[1] = seg_id1_in;
  assign seg_id[2] = seg_id2_in;
  assign seg_id[3] = seg_id3_in;
  assign seg_id[4] = seg_id4_in;

  // control register: bit0 software disable of fair mode overlay
  reg  [7:0] ctrl_q;
  reg  [7:0] irq_q;
  reg  [7:0] mask_q;
  wire       fair_on = fair_sel_in & ~ctrl_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // port enables follow termination power, each port independently
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_en_out <= {NPORT{1'b0}};
    end else begin
      port_en_out <= tpwr_in;
    end
  end

  // merged bus state over enabled segments only
  reg  [IDW-1:0] or_id;
  reg            or_bsy;
  reg            or_sel;
  integer        i;
  always @* begin
    or_id  = {IDW{1'b0}};
    or_bsy = 1'b0;
    or_sel = 1'b0;
    for (i = 0; i < NPORT; i = i + 1) begin
      if (port_en_out[i]) begin
        or_id  = or_id | seg_id[i];
        or_bsy = or_bsy | seg_bsy_in[i];
        or_sel = or_sel | seg_sel_in[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host request bits at fixed port ids; foreign ids flag a bad setup
  reg  [3:0]     host_req;
  reg            ctl_req;
  reg            bad_id;
  reg  [IDW-1:0] legal;
  reg  [IDW-1:0] ctl_gid;
  integer        k;
  always @* begin
    host_req = 4'h0;
    legal    = {IDW{1'b0}};
    ctl_gid  = {IDW{1'b0}};
    for (k = 0; k < 4; k = k + 1) begin
      host_req[k] = port_en_out[k] & seg_id[k][host_base + k[3:0]];
      legal[host_base + k[3:0]] = 1'b1;
    end
    ctl_req = 1'b0;
    for (k = 0; k < 7; k = k + 1) begin
      if (k[3:0] >= ctl_lo) begin
        ctl_req = ctl_req | (port_en_out[`SHFA_CTL_PORT] & seg_id[`SHFA_CTL_PORT][k]);
        legal[k] = 1'b1;
        // ascending scan, so the highest requesting controller id is kept
        if (port_en_out[`SHFA_CTL_PORT] & seg_id[`SHFA_CTL_PORT][k]) begin
          ctl_gid = {{(IDW-1){1'b0}}, 1'b1} << k;
        end
      end
    end
    bad_id = fair_on & or_bsy & ~or_sel & (|(or_id & ~legal));
  end

  ////////////////////////////////////////////////////////////////////////////
  // fair scheduler: capture group, grant highest, remove, wait for free bus
  reg  [1:0] st_q;
  reg  [3:0] group_q;
  reg  [1:0] sel_idx;
  reg        pick_ok;
  integer    j;
  always @* begin
    sel_idx = 2'h0;
    pick_ok = 1'b0;
    for (j = 0; j < 4; j = j + 1) begin
      if (group_q[j]) begin
        sel_idx = j[1:0];
        pick_ok = 1'b1;
      end
    end
  end

  wire arb_phase = or_bsy & ~or_sel;
  reg  ev_grant;
  reg  ev_cap;
  reg  took_q;    // granted owner has been seen on the bus
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q         <= `SHFA_ST_IDLE;
      group_q      <= 4'h0;
      grant_id_out <= {IDW{1'b0}};
      grant_valid_out <= 1'b0;
      ev_grant     <= 1'b0;
      ev_cap       <= 1'b0;
      took_q       <= 1'b0;
    end else begin
      ev_grant <= 1'b0;
      ev_cap   <= 1'b0;
      case (st_q)
        `SHFA_ST_IDLE: begin
          grant_valid_out <= 1'b0;
          if (fair_on && ctl_req && arb_phase) begin
            grant_id_out    <= ctl_gid;
            grant_valid_out <= 1'b1;
            ev_grant        <= 1'b1;
            st_q            <= `SHFA_ST_WAIT;
          end else if (fair_on && pick_ok) begin
            st_q <= `SHFA_ST_GRANT;
          end else if (fair_on && arb_phase && |host_req) begin
            group_q <= host_req;
            ev_cap  <= 1'b1;
            st_q    <= `SHFA_ST_GRANT;
          end
        end
        `SHFA_ST_GRANT: begin
          grant_id_out    <= {{(IDW-1){1'b0}}, 1'b1} << (host_base + {2'b00, sel_idx});
          grant_valid_out <= 1'b1;
          group_q[sel_idx] <= 1'b0;
          ev_grant <= 1'b1;
          st_q     <= `SHFA_ST_WAIT;
        end
        `SHFA_ST_WAIT: begin
          // wait for the owner to take the bus, then for it to let go;
          // an owner that never shows up leaves the hub waiting here
          if (or_bsy && or_sel) begin
            took_q <= 1'b1;
          end else if (took_q && !or_bsy) begin
            took_q          <= 1'b0;
            grant_valid_out <= 1'b0;
            st_q <= `SHFA_ST_IDLE;
          end
        end
        default: st_q <= `SHFA_ST_IDLE;
      endcase
      if (!fair_on) begin
        group_q <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus drive: fair mode shows hub id then the granted id; off, pass through
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_id_out  <= {IDW{1'b0}};
      bus_bsy_out <= 1'b0;
      bus_sel_out <= 1'b0;
    end else begin
      bus_bsy_out <= or_bsy;
      bus_sel_out <= or_sel;
      if (fair_on && arb_phase) begin
        // hub asserts id 7 to win, then lets the granted id through
        bus_id_out <= grant_valid_out ? grant_id_out
                    : ({{(IDW-1){1'b0}}, 1'b1} << `SHFA_HUB_ID);
      end else begin
        // all ids pass; winner is the highest asserted, no port binding
        bus_id_out <= or_id;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_led_out <= 1'b0;
      busy_led_out  <= 1'b0;
    end else begin
      power_led_out <= 1'b1;
      busy_led_out  <= or_bsy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; set beats read-clear so no event is lost
  reg  [NPORT-1:0] tpwr_q;
  wire [7:0]       ev;
  assign ev = {4'h0, bad_id, ev_cap, ev_grant, |(tpwr_q & ~tpwr_in)};
  wire rd_irq = reg_rd_in && (reg_addr_in == `SHFA_REG_IRQ);

  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q        <= `SHFA_CTRL_RST;
      mask_q        <= `SHFA_MASK_RST;
      irq_q         <= 8'h0_0;
      tpwr_q        <= {NPORT{1'b0}};
      reg_rdata_out <= 8'h0_0;
      irq_out       <= 1'b0;
    end else begin
      tpwr_q  <= tpwr_in;
      irq_q   <= (rd_irq ? 8'h0_0 : irq_q) | ev;
      irq_out <= |(irq_q & mask_q);
      if (reg_wr_in) begin
        case (reg_addr_in)
          `SHFA_REG_CTRL: ctrl_q <= reg_wdata_in;
          `SHFA_REG_MASK: mask_q <= reg_wdata_in;
          default: ;
        endcase
      end
      reg_rdata_out <= 8'h0_0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `SHFA_REG_CTRL:  reg_rdata_out <= ctrl_q;
          `SHFA_REG_STAT:  reg_rdata_out <= {st_q, fair_on, port_en_out};
          `SHFA_REG_IRQ:   reg_rdata_out <= irq_q;
          `SHFA_REG_MASK:  reg_rdata_out <= mask_q;
          `SHFA_REG_GRANT: reg_rdata_out <= {group_q, grant_id_out[15:12] | grant_id_out[3:0]};
          default:         reg_rdata_out <= 8'h0_0;
        endcase
      end
    end
  end

endmodule

/* testbench/shfa_hub_asserts.sv */
// port checker for the hub arbiter
// assumes it is bound onto every instance of shfa_hub_arbiter
module shfa_hub_asserts #(
  parameter NPORT = 5,
  parameter IDW   = 16
) (
  // clock, reset and inputs
  input wire logic             clock_in,
  input wire logic             rstn_in,
  input wire logic             fair_sel_in,
  input wire logic [NPORT-1:0] tpwr_in,
  input wire logic [NPORT-1:0] seg_bsy_in,
  input wire logic             reg_rd_in,
  // outputs
  input wire logic [7:0]       reg_rdata_out,
  input wire logic [NPORT-1:0] port_en_out,
  input wire logic [IDW-1:0]   grant_id_out,
  input wire logic             grant_valid_out,
  input wire logic             power_led_out,
  input wire logic             busy_led_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////
  // grant start and a grant held from the previous cycle
  sequence s_grant_start;
    $rose(grant_valid_out);
  endsequence
  sequence s_grant_held;
    grant_valid_out && $past(grant_valid_out);
  endsequence
  chk_power_on: assert property (1 |=> power_led_out)
    else $error("power indicator low");
  chk_busy_set: assert property (|(seg_bsy_in & port_en_out & tpwr_in) |=> busy_led_out)
    else $error("busy indicator missed");
  chk_busy_clear: assert property (!(|seg_bsy_in) |=> !busy_led_out)
    else $error("busy indicator stuck");
  chk_port_off: assert property (1 |=> port_en_out == $past(tpwr_in))
    else $error("port enable wrong");
  chk_grant_onehot: assert property (grant_valid_out |-> $onehot(grant_id_out))
    else $error("grant not one id");
  chk_hub_id: assert property (grant_valid_out |-> !grant_id_out[7])
    else $error("hub id granted");
  chk_grant_hold: assert property (s_grant_held |-> $stable(grant_id_out))
    else $error("grant id moved");
  chk_grant_fair: assert property (s_grant_start |-> $past(fair_sel_in))
    else $error("grant without fair");
  chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  cover property (s_grant_start ##1 s_grant_held);
endmodule
bind shfa_hub_arbiter shfa_hub_asserts #(.NPORT(NPORT), .IDW(IDW)) i_shfa_hub_asserts (
  .clock_in(clock_in), .rstn_in(rstn_in), .fair_sel_in(fair_sel_in), .tpwr_in(tpwr_in),
  .seg_bsy_in(seg_bsy_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .port_en_out(port_en_out), .grant_id_out(grant_id_out), .grant_valid_out(grant_valid_out),
  .power_led_out(power_led_out), .busy_led_out(busy_led_out));

/* testbench/shfa_host_model.sv */
// host adapters on segments 0..3; the controller segment stays quiet
// assumes a one-cycle arbitration pulse from the bench
module shfa_host_model (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        arb_in,
  input  wire logic [3:0]  req_in,
  input  wire logic        narrow_in,
  input  wire logic        gnt_in,
  input  wire logic [15:0] gnt_id_in,
  input  wire logic [3:0]  use_len_in,
  output logic      [4:0]  bsy_out,
  output logic      [4:0]  sel_out,
  output logic      [63:0] id_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic gnt_q;
  int   cnt;
  // released lines fall idle; a host owns the bus for use_len cycles
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bsy_out <= '0;
      sel_out <= '0;
      id_out <= '0;
      gnt_q <= 1'b0;
      cnt <= 0;
    end else begin
      gnt_q <= gnt_in;
      bsy_out <= '0;
      sel_out <= '0;
      id_out <= '0;
      if (arb_in) begin
        bsy_out <= {1'b0, req_in};
        for (int p = 0; p < 4; p++)
          if (req_in[p]) id_out[p*16 +: 16] <= 16'h1 << (narrow_in ? p : p + 12);
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
        bsy_out <= bsy_out;
        sel_out <= sel_out;
      end else if (gnt_in && !gnt_q) begin
        cnt <= use_len_in;
        for (int p = 0; p < 4; p++)
          if (gnt_id_in == 16'h1 << (narrow_in ? p : p + 12)) begin
            bsy_out[p] <= 1'b1;
            sel_out[p] <= 1'b1;
          end
      end
    end
  end
endmodule

/* testbench/tb_shfa_hub_arbiter.sv */
// self-checking bench for the hub arbiter
// assumes the host model stands on all host segments
module tb_shfa_hub_arbiter;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in = 0;
  logic        rstn_in = 0;
  logic        fair_sel = 1;
  logic        jumper = 1;
  logic        arb = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic [3:0]  req = 0;
  logic [3:0]  use_len = 2;
  logic [3:0]  addr = 0;
  logic [7:0]  wdata = 0;
  logic [4:0]  tpwr = 5'h1f;
  logic [4:0]  bsy, sel, pen;
  logic [63:0] ids;
  logic [7:0]  rdata;
  logic [15:0] gid, bid;
  logic        gv, gv_q, pled, irq;
  logic [15:0] got[$], exp[$];
  int          error_cnt = 0;
  int          check_count = 0;
  int          seed = 32'ha49aee26;
  shfa_hub_arbiter i_shfa_hub_arbiter (
    .clock_in(clock_in), .rstn_in(rstn_in), .fair_sel_in(fair_sel),
    .addr_mode_jumper_in(jumper), .tpwr_in(tpwr), .seg_bsy_in(bsy), .seg_sel_in(sel),
    .seg_id0_in(ids[15:0]), .seg_id1_in(ids[31:16]), .seg_id2_in(ids[47:32]),
    .seg_id3_in(ids[63:48]), .seg_id4_in(16'h0000), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .port_en_out(pen), .bus_bsy_out(), .bus_sel_out(), .bus_id_out(bid), .grant_id_out(gid),
    .grant_valid_out(gv), .power_led_out(pled), .busy_led_out(), .irq_out(irq));
  shfa_host_model i_shfa_host_model (
    .clock_in(clock_in), .rstn_in(rstn_in), .arb_in(arb), .req_in(req), .narrow_in(jumper),
    .gnt_in(gv), .gnt_id_in(gid), .use_len_in(use_len), .bsy_out(bsy), .sel_out(sel),
    .id_out(ids));
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  // grant log: one entry per new grant
  always @(posedge clock_in) begin
    gv_q <= gv;
    if (gv === 1'b1 && gv_q !== 1'b1) got.push_back(gid);
  end
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_in);
    rd <= 1;
    addr <= a;
    @(posedge clock_in);
    rd <= 0;
    #1 check({8'h00, rdata}, {8'h00, e});
  endtask
  // one arbitration by the hosts in m; model: enabled hosts, highest id first
  task automatic round(input logic [3:0] m);
    logic [15:0] idsum;
    got.delete();
    exp.delete();
    idsum = 16'h0000;
    @(posedge clock_in);
    for (int p = 3; p >= 0; p--)
      if (m[p] && tpwr[p]) begin
        idsum = idsum | (16'h1 << (jumper ? p : p + 12));
        if (fair_sel) exp.push_back(16'h1 << (jumper ? p : p + 12));
      end
    arb <= 1;
    req <= m;
    use_len <= 4'($random(seed) & 3) + 4'h1;
    @(posedge clock_in);
    arb <= 0;
    @(posedge clock_in);
    #1 check(bid, fair_sel ? 16'h0080 : idsum);
    for (int n = 0; n < 300 && got.size() < exp.size(); n++) @(posedge clock_in);
    repeat (20) @(posedge clock_in);
    check(16'(got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
    if (got.size() != exp.size()) print_verdict();
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    rstn_in <= 1;
    reg_wr(4'h3, 8'h02);
    #1 check({15'h0, pled}, 16'h1);
    check({15'h0, irq}, 16'h0);
    for (int j = 1; j >= 0; j--) begin
      jumper <= j[0];
      repeat (2) @(posedge clock_in);
      round(4'($random(seed)) | 4'h1);
      round(4'hf);
    end
    #1 check({15'h0, irq}, 16'h1);
    reg_rd(4'h2, 8'h06);
    reg_rd(4'h2, 8'h00);
    reg_rd(4'hf, 8'h00);
    reg_rd(4'h1, 8'h3f);
    reg_wr(4'h0, 8'h01);
    reg_rd(4'h1, 8'h1f);
    reg_wr(4'h0, 8'h00);
    @(posedge clock_in);
    tpwr <= 5'h1d;
    repeat (3) @(posedge clock_in);
    #1 check({11'h0, pen}, 16'h001d);
    reg_rd(4'h2, 8'h01);
    round(4'hf);
    fair_sel <= 0;
    round(4'hf);
    print_verdict();
  end
endmodule
